// ==== bench/fsr_egress_model.sv ====
`timescale 1ns/1ps
module fsr_egress_model (
   input wire logic clk,
   output fsr_pkg::fsr_frame_s frame,
   output fsr_pkg::fsr_ts_s tsIn
);
   import fsr_pkg::*;
   initial begin
      frame = '0;
      tsIn = '0;
   end
   // ----------------
   // frame sequencing
   // ----------------
   // data lines off the end cycle carry the inverse
   function automatic fsr_frame_s idle(input fsr_frame_s f);
      fsr_frame_s g;
      g = ~f;
      g.frameStart = 1'b0;
      g.frameEnd = 1'b0;
      g.mplsDone = 1'b0;
      return g;
   endfunction
   // hits assume chained comparators spaced one word apart
   task automatic run(input fsr_frame_s f, input int gap);
      fsr_frame_s g;
      g = idle(f);
      g.frameStart = 1'b1;
      @(posedge clk);
      frame <= g;
      for (int i = 0; i < gap; i++) begin
         g = idle(f);
         g.mplsDone = f.mplsDone && i == 0;
         @(posedge clk);
         frame <= g;
      end
      g = f;
      g.frameStart = 1'b0;
      g.mplsDone = 1'b0;
      g.frameEnd = 1'b1;
      @(posedge clk);
      frame <= g;
      tsIn <= '{1'b1, f.hdr[79:0]};
      @(posedge clk);
      frame <= idle(f);
      tsIn <= '{1'b0, ~f.hdr[79:0]};
   endtask
endmodule

// ==== bench/fsr_frame_sig_bench.sv ====
`timescale 1ns/1ps
module fsr_frame_sig_bench;
   import fsr_pkg::*;
   logic clk = 1'b0;
   logic rst_b;
   fsr_apb_req_s apbReq;
   fsr_apb_rsp_s apbRsp;
   fsr_frame_s frame;
   fsr_ts_s tsIn;
   fsr_fifo_s fifoOut;
   fsr_match_s matchOut;
   logic [2:0] engActive;
   logic [2:0][2:0] compActive;
   logic achStart;
   logic achSeen;
   logic [31:0] rd;
   logic err;
   fsr_frame_s f;
   int miscompares = 0;
   int numChecks = 0;
   always #5 clk = ~clk;
   always @(posedge clk) if (achStart === 1'b1) achSeen <= 1'b1;
   fsr_frame_sig u_fsr_frame_sig (.clk(clk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
      .frame(frame), .tsIn(tsIn), .fifoOut(fifoOut), .matchOut(matchOut), .engActive(engActive),
      .compActive(compActive), .achStart(achStart));
   fsr_egress_model u_fsr_egress_model (.clk(clk), .frame(frame), .tsIn(tsIn));
   // -------------
   // shared tasks
   // -------------
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      numChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      apbReq <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      @(posedge clk);
      while (apbRsp.pready !== 1'b1) @(posedge clk);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq <= '0;
   endtask
   task automatic frameCheck(input logic [10:0] exp);
      u_fsr_egress_model.run(f, 3);
      #1;
      check({matchOut.valid, matchOut.stampAll, matchOut.flows, matchOut.sets}, {1'b1, exp});
   endtask
   function automatic logic [7:0] expByte(input logic [5:0] s, input logic [63:0] a);
      if (s <= 6'h17) return f.hdr[8 * (31 - int'(s)) +: 8];
      case (s)
         6'h18: return f.hdr[55:48];
         6'h19: return f.hdr[39:32];
         6'h1a: return f.hdr[7:0];
         6'h1b: return 8'h00;
         default: return a[8 * (int'(s) - 28) +: 8];
      endcase
   endfunction
   // ----------
   // scenarios
   // ----------
   task automatic regScan;
      apb(0, FSR_COMP_EN_OFS, 0);
      check(rd, 32'h1ff);
      apb(0, FSR_CHAN_MASK_OFS, 0);
      check(rd, 32'hffff);
      apb(0, FSR_SIG_SEL_OFS + 12'h3c, 0);
      check(rd, 32'h1b);
      apb(1, FSR_SIG_SEL_OFS + 12'h14, 32'hffffffff);
      apb(0, FSR_SIG_SEL_OFS + 12'h14, 0);
      check(rd, 32'h3f);
      apb(1, FSR_ADDR_CFG_OFS, 32'hffffffff);
      apb(0, FSR_ADDR_CFG_OFS, 0);
      check(rd, 32'hf3);
      apb(0, 12'h0fc, 0);
      check({err, rd}, 33'h100000000);
      apb(0, FSR_ENG_CTRL_OFS + 12'h2, 0);
      check(err, 1'b1);
   endtask
   task automatic sigScan;
      logic [63:0] a;
      logic [127:0] e;
      logic [5:0] s;
      for (int n = 0; n < 32; n++) f.hdr[8 * n +: 8] = 8'(n * 7 + 3);
      for (int b = 0; b < 4; b++) begin
         for (int n = 0; n < 8; n++) begin
            f.srcAddr[b][8 * n +: 8] = 8'(128 + 16 * b + n);
            f.dstAddr[b][8 * n +: 8] = 8'(16 * b + n);
         end
      end
      apb(1, FSR_ENG_CTRL_OFS, 32'h7);
      // pass 4 is engine C part B with the second ethernet block
      for (int src = 0; src < 5; src++) begin
         f.engine = (src == 4) ? 2'h2 : 2'h0;
         f.partB = (src == 4);
         apb(1, FSR_ADDR_CFG_OFS, {24'h0, 4'h5, 2'h0, 2'(src == 4 ? 1 : src)});
         a = (src == 4) ? 64'h0 : (src % 2) ? f.srcAddr[src % 4] : f.dstAddr[src % 4];
         for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 16; i++) begin
               s = (k * 16 + i > 35) ? 6'h1b : 6'(k * 16 + i);
               e[8 * i +: 8] = expByte(s, a);
               apb(1, FSR_SIG_SEL_OFS + 12'(4 * i), {26'h0, s});
            end
            u_fsr_egress_model.run(f, 2);
            #1;
            check(fifoOut.sig, e);
            check({fifoOut.valid, fifoOut.ts}, {1'b1, f.hdr[79:0]});
            apb(0, FSR_SIG_RD_OFS + 12'hc, 0);
            check(rd, e[127:96]);
         end
      end
   endtask
   task automatic flowScan;
      f.engine = 2'h0;
      f.partB = 1'b0;
      f.ethFound = 1'b1;
      f.hit = {24{2'b01}};
      apb(1, FSR_ENG_CTRL_OFS, 32'h1);
      apb(1, FSR_STAGE_EN_OFS, 32'hffffff);
      frameCheck(11'h3fd);
      f.hit[1] = {8{2'b10}};
      frameCheck(11'h000);
      f.hit = {24{2'b01}};
      apb(1, FSR_PGRP_MASK_OFS, 32'haaaa);
      frameCheck(11'h000);
      apb(1, FSR_PGRP_MASK_OFS, 32'hffff);
      apb(1, FSR_CHAN_MASK_OFS, 32'haa55);
      f.chan = 1'b1;
      frameCheck({1'b0, 8'hf0, 2'h1});
      f.chan = 1'b0;
      frameCheck({1'b0, 8'h0f, 2'h1});
      apb(1, FSR_CHAN_MASK_OFS, 32'hffff);
      f.ethFound = 1'b0;
      frameCheck(11'h000);
      f.ethFound = 1'b1;
      apb(1, FSR_ENG_CTRL_OFS, 0);
      apb(1, FSR_COMP_EN_OFS, 32'h1fd);
      apb(1, FSR_STAGE_EN_OFS, 32'hfffeff);
      apb(1, FSR_ENG_CTRL_OFS, 32'h1);
      frameCheck(11'h3fd);
      apb(1, FSR_ENG_CTRL_OFS, 32'h101);
      frameCheck({1'b0, 8'hfe, 2'h1});
      apb(1, FSR_ENG_CTRL_OFS, 0);
      apb(1, FSR_COMP_EN_OFS, 32'h1fe);
      apb(1, FSR_ENG_CTRL_OFS, 32'h1);
      u_fsr_egress_model.run(f, 2);
      #1;
      check(matchOut.stampAll, 1'b1);
      check(compActive, 9'h1fe);
      apb(0, FSR_STATUS_OFS, 0);
      check(rd, 32'h00ff00b1);
      apb(1, FSR_COMP_EN_OFS, 32'h1ff);
   endtask
   task automatic gapScan;
      fork
         u_fsr_egress_model.run(f, 8);
         begin
            apb(1, FSR_ENG_CTRL_OFS, 32'h2);
            #1;
            check(engActive, 3'h1);
         end
      join
      #1;
      check(engActive, 3'h2);
      apb(1, FSR_STAGE_EN_OFS, 32'h123456);
      apb(0, FSR_STAGE_EN_OFS, 0);
      check(rd, 32'h123456);
      apb(1, FSR_STAGE_EN_OFS + 12'h4, 32'hffffff);
      f.engine = 2'h1;
      frameCheck(11'h3fd);
      apb(1, FSR_ENG_CTRL_OFS, 32'h4);
      apb(1, FSR_STAGE_EN_OFS + 12'h8, 32'hffffff);
      f.engine = 2'h2;
      f.mplsDone = 1'b1;
      achSeen = 1'b0;
      frameCheck(11'h3fd);
      check(achSeen, 1'b1);
   endtask
   initial begin
      rst_b = 1'b0;
      apbReq = '0;
      f = '0;
      achSeen = 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      regScan();
      sigScan();
      flowScan();
      gapScan();
      end_of_test();
   end
   initial begin
      #500000;
      miscompares++;
      end_of_test();
   end
endmodule

// ==== bench/fsr_frame_sig_properties.sv ====
`timescale 1ns/1ps
module fsr_frame_sig_properties #(
   parameter int FLOWS = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire fsr_pkg::fsr_apb_req_s apbReq,
   input wire fsr_pkg::fsr_apb_rsp_s apbRsp,
   input wire fsr_pkg::fsr_frame_s frame,
   input wire fsr_pkg::fsr_ts_s tsIn,
   input wire fsr_pkg::fsr_fifo_s fifoOut,
   input wire fsr_pkg::fsr_match_s matchOut,
   input wire logic [2:0] engActive,
   input wire logic [2:0][2:0] compActive,
   input wire logic achStart
);
   import fsr_pkg::*;
   logic busy_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ---------------
   // frame tracking
   // ---------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
      end else if (frame.frameStart) begin
         busy_r <= 1'b1;
      end else if (frame.frameEnd) begin
         busy_r <= 1'b0;
      end
   end
   chk_ts_delay: assert property (tsIn.tsDone |=> fifoOut.valid && fifoOut.ts == $past(tsIn.ts))
      else $error("time stamp not delivered");
   chk_ts_cause: assert property (fifoOut.valid |-> $past(tsIn.tsDone))
      else $error("storage write without capture");
   chk_sig_hold: assert property (!$past(tsIn.tsDone) |-> $stable(fifoOut.sig))
      else $error("signature moved between captures");
   chk_eng_gap: assert property (!$stable(engActive) |-> !$past(busy_r) || $past(frame.frameEnd))
      else $error("engine enable changed inside frame");
   chk_comp_gap: assert property (!$stable(compActive) |-> !$past(busy_r) || $past(frame.frameEnd))
      else $error("comparator enable changed inside frame");
   chk_ach_cause: assert property (achStart |-> $past(frame.mplsDone) && $past(engActive[2]))
      else $error("ach start without mpls completion");
   chk_match_time: assert property (frame.frameEnd |=> matchOut.valid)
      else $error("match result late");
   chk_match_hold: assert property (!$past(frame.frameEnd) |-> $stable({matchOut.flows, matchOut.sets}))
      else $error("match result moved");
   chk_noeth_empty: assert property (matchOut.valid && !matchOut.stampAll && !$past(frame.ethFound)
      |-> matchOut.flows == '0 && matchOut.sets == 2'h0)
      else $error("flow matched without ethernet header");
   chk_bad_addr: assert property (apbReq.psel && apbReq.penable && apbReq.paddr[1:0] != 2'h0
      |-> apbRsp.pslverr)
      else $error("misaligned access accepted");
   cover property (matchOut.valid && matchOut.stampAll);
   cover property (achStart);
   cover property (fifoOut.valid && matchOut.valid);
endmodule
bind fsr_frame_sig fsr_frame_sig_properties #(.FLOWS(FLOWS)) u_fsr_frame_sig_properties (.clk(clk),
   .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp), .frame(frame), .tsIn(tsIn), .fifoOut(fifoOut),
   .matchOut(matchOut), .engActive(engActive), .compActive(compActive), .achStart(achStart));

// ==== rtl/fsr_frame_sig.sv ====
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
module fsr_frame_sig #(
   parameter int FLOWS = fsr_pkg::FSR_FLOWS
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire fsr_pkg::fsr_apb_req_s apbReq,
   output fsr_pkg::fsr_apb_rsp_s apbRsp,
   input wire fsr_pkg::fsr_frame_s frame,
   input wire fsr_pkg::fsr_ts_s tsIn,
   output fsr_pkg::fsr_fifo_s fifoOut,
   output fsr_pkg::fsr_match_s matchOut,
   output logic [2:0] engActive,
   output logic [2:0][2:0] compActive,
   output logic achStart
);
   import fsr_pkg::*;

   // ----------------------------------------
   // configuration state
   // ----------------------------------------
   logic [2:0] engEn_r;
   logic strict_r;
   logic [2:0][23:0] stageEn_r;
   logic [8:0] compEn_r;
   logic [1:0] addrSrc_r;
   logic [3:0] addrDst_r;
   logic [15:0] chanMask_r;
   logic [15:0] pgrpMask_r;
   logic [FSR_SIGBYTES-1:0][5:0] sigSel_r;
   logic [2:0] engAct_r;
   logic [2:0][23:0] stageAct_r;
   logic [8:0] compAct_r;
   logic busy_r;
   logic [127:0] sig_r;
   logic [127:0] sigNxt;
   logic sigReady_r;
   logic [31:0] prdata_r;
   fsr_fifo_s fifo_r;
   fsr_match_s match_r;
   fsr_match_s matchNxt;
   logic ach_r;

   // ----------------------------------------
   // signature byte decode
   // ----------------------------------------
   function automatic logic [7:0] sigByte(input logic [5:0] sel, input logic [255:0] hdr,
                                         input logic [63:0] adr);
      logic [5:0] idx;
      idx = 6'h00;
      sigByte = 8'h00;
      if (sel <= FSR_SEL_HDR_MAX) begin
         idx = FSR_HDR_TOP - sel;
         sigByte = hdr[idx*8 +: 8];
      end else if (sel >= FSR_SEL_ADDR_MIN && sel <= FSR_SEL_ADDR_MAX) begin
         idx = sel - FSR_SEL_ADDR_MIN;
         sigByte = adr[idx[2:0]*8 +: 8];
      end else begin
         case (sel)
            FSR_SEL_HDR6: sigByte = hdr[6*8 +: 8];
            FSR_SEL_HDR4: sigByte = hdr[4*8 +: 8];
            FSR_SEL_HDR0: sigByte = hdr[7:0];
            default: sigByte = 8'h00;
         endcase
      end
   endfunction

   function automatic logic regHit(input logic [11:0] a, input logic [11:0] ofs);
      regHit = (a == ofs);
   endfunction

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   logic setupPh;
   logic accessPh;
   logic wrEn;
   logic mapped;
   logic [31:0] rdMux;
   logic [11:0] pa;

   assign pa = apbReq.paddr;
   assign setupPh = apbReq.psel && !apbReq.penable;
   assign accessPh = apbReq.psel && apbReq.penable;
   assign wrEn = accessPh && apbReq.pwrite;

   always_comb begin
      mapped = 1'b1;
      rdMux = 32'h00000000;
      if (regHit(pa, FSR_ENG_CTRL_OFS)) begin
         rdMux = {23'h000000, strict_r, 5'h00, engEn_r};
      end else if (regHit(pa, FSR_STATUS_OFS)) begin
         rdMux = {7'h00, match_r.sets, match_r.flows, 7'h00, sigReady_r, busy_r, compAct_r[2:0], engAct_r};
      end else if (regHit(pa, FSR_COMP_EN_OFS)) begin
         rdMux = {23'h000000, compEn_r};
      end else if (regHit(pa, FSR_ADDR_CFG_OFS)) begin
         rdMux = {24'h000000, addrDst_r, 2'h0, addrSrc_r};
      end else if (regHit(pa, FSR_CHAN_MASK_OFS)) begin
         rdMux = {16'h0000, chanMask_r};
      end else if (regHit(pa, FSR_PGRP_MASK_OFS)) begin
         rdMux = {16'h0000, pgrpMask_r};
      end else if (pa[11:4] == FSR_STAGE_EN_OFS[11:4] && pa[3:2] != 2'h3 && pa[1:0] == 2'h0) begin
         rdMux = {8'h00, stageEn_r[pa[3:2]]};
      end else if (pa[11:6] == FSR_SIG_SEL_OFS[11:6] && pa[1:0] == 2'h0) begin
         rdMux = {26'h0000000, sigSel_r[pa[5:2]]};
      end else if (pa[11:4] == FSR_SIG_RD_OFS[11:4] && pa[1:0] == 2'h0) begin
         rdMux = sig_r[pa[3:2]*32 +: 32];
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prdata_r <= 32'h00000000;
      end else if (setupPh) begin
         prdata_r <= apbReq.pwrite ? 32'h00000000 : rdMux;
      end
   end

   assign apbRsp.prdata = prdata_r;
   assign apbRsp.pready = 1'b1;
   assign apbRsp.pslverr = accessPh && !mapped;

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         engEn_r <= FSR_ENG_EN_RST;
         strict_r <= 1'b0;
         compEn_r <= FSR_COMP_EN_RST;
         addrSrc_r <= 2'h0;
         addrDst_r <= 4'h0;
         chanMask_r <= FSR_CHAN_MASK_RST;
         pgrpMask_r <= FSR_PGRP_MASK_RST;
      end else if (wrEn) begin
         if (regHit(pa, FSR_ENG_CTRL_OFS)) begin
            engEn_r <= apbReq.pwdata[2:0];
            strict_r <= apbReq.pwdata[FSR_STRICT_BIT];
         end
         if (regHit(pa, FSR_COMP_EN_OFS)) begin
            compEn_r <= apbReq.pwdata[8:0];
         end
         if (regHit(pa, FSR_ADDR_CFG_OFS)) begin
            addrSrc_r <= apbReq.pwdata[1:0];
            addrDst_r <= apbReq.pwdata[FSR_ADDRDST_LSB +: 4];
         end
         if (regHit(pa, FSR_CHAN_MASK_OFS)) begin
            chanMask_r <= apbReq.pwdata[15:0];
         end
         if (regHit(pa, FSR_PGRP_MASK_OFS)) begin
            pgrpMask_r <= apbReq.pwdata[15:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stageEn_r <= {3{FSR_STAGE_EN_RST}};
      end else if (wrEn && pa[11:4] == FSR_STAGE_EN_OFS[11:4] && pa[3:2] != 2'h3 && pa[1:0] == 2'h0) begin
         stageEn_r[pa[3:2]] <= apbReq.pwdata[23:0];
      end
   end

   // one 6-bit select per signature byte
   genvar gi;
   generate
      for (gi = 0; gi < FSR_SIGBYTES; gi++) begin : g_sel
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               sigSel_r[gi] <= FSR_SIG_SEL_RST;
            end else if (wrEn && pa == (FSR_SIG_SEL_OFS + 12'(gi * 4))) begin
               sigSel_r[gi] <= apbReq.pwdata[5:0];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // clean enable switching
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
      end else if (frame.frameStart) begin
         busy_r <= 1'b1;
      end else if (frame.frameEnd) begin
         busy_r <= 1'b0;
      end
   end

   // copy to active set outside a frame or in its frameEnd cycle
   // each engine switched on its own bit
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         engAct_r <= FSR_ENG_EN_RST;
         stageAct_r <= {3{FSR_STAGE_EN_RST}};
         compAct_r <= FSR_COMP_EN_RST;
      end else if (!busy_r || frame.frameEnd) begin
         engAct_r <= engEn_r;
         stageAct_r <= stageEn_r;
         compAct_r <= compEn_r;
      end
   end

   // ----------------------------------------
   // flow match with protocol sets
   // ----------------------------------------
   always_comb begin
      logic [FLOWS-1:0] flowOn;
      logic [FLOWS-1:0] pass;
      logic [1:0] prevSets;
      logic [1:0] stageSets;
      logic [1:0] eng;
      logic [1:0] ok;
      flowOn = '0;
      pass = '0;
      prevSets = 2'h3;
      stageSets = 2'h0;
      eng = frame.engine;
      ok = 2'h0;
      matchNxt = '0;
      for (int f = 0; f < FLOWS; f++) begin
         pass[f] = engAct_r[eng] && chanMask_r[2*f + int'(frame.chan)];
         // strict mode ands flow across stages
         flowOn[f] = strict_r ? (stageAct_r[eng][f] && stageAct_r[eng][8+f] && stageAct_r[eng][16+f]) : 1'b1;
         pass[f] = pass[f] && flowOn[f];
      end
      for (int s = 0; s < FSR_STAGES; s++) begin
         if (compAct_r[3*eng + s]) begin
            stageSets = 2'h0;
            for (int f = 0; f < FLOWS; f++) begin
               // only sets matched earlier, group mask
               ok = frame.hit[s][f] & prevSets & pgrpMask_r[2*f +: 2];
               pass[f] = pass[f] && stageAct_r[eng][8*s + f] && (ok != 2'h0);
               if (pass[f]) begin
                  stageSets = stageSets | ok;
               end
            end
            // set bits from each enabled stage, carried on
            prevSets = stageSets;
         end
      end
      // no Ethernet header kills all flows when first Ethernet is on
      if (compAct_r[3*eng] && !frame.ethFound) begin
         pass = '0;
         prevSets = 2'h0;
      end
      matchNxt.valid = frame.frameEnd;
      // first Ethernet off stamps every frame of an active engine
      matchNxt.stampAll = engAct_r[eng] && !compAct_r[3*eng];
      matchNxt.flows = pass;
      matchNxt.sets = prevSets;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         match_r <= '0;
      end else if (frame.frameEnd) begin
         match_r <= matchNxt;
      end else begin
         match_r.valid <= 1'b0;
      end
   end

   // ACH start right after MPLS stage
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ach_r <= 1'b0;
      end else begin
         ach_r <= frame.mplsDone && engAct_r[FSR_ENGINE_C] && busy_r;
      end
   end

   // ----------------------------------------
   // signature builder
   // ----------------------------------------
   logic [63:0] selAddr;
   always_comb begin
      selAddr = addrDst_r[addrSrc_r] ? frame.dstAddr[addrSrc_r] : frame.srcAddr[addrSrc_r];
      // part B only has first Ethernet
      // zeros when part B asks for second Ethernet
      if (frame.engine == FSR_ENGINE_C && frame.partB && addrSrc_r == 2'h1) begin
         selAddr = 64'h0000000000000000;
      end
   end

   // up to sixteen bytes, byte 0 lowest
   generate
      for (gi = 0; gi < FSR_SIGBYTES; gi++) begin : g_sig
         assign sigNxt[gi*8 +: 8] = sigByte(sigSel_r[gi], frame.hdr, selAddr);
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sig_r <= 128'h0;
      end else if (frame.frameEnd) begin
         sig_r <= sigNxt;
      end
   end

   // set wins over the clear of the same cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sigReady_r <= 1'b0;
      end else if (frame.frameEnd) begin
         sigReady_r <= 1'b1;
      end else if (tsIn.tsDone) begin
         sigReady_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // egress time stamp storage output
   // ----------------------------------------
   // signature paired with capture result
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         fifo_r <= '0;
      end else begin
         fifo_r.valid <= tsIn.tsDone;
         if (tsIn.tsDone) begin
            fifo_r.sig <= frame.frameEnd ? sigNxt : sig_r;
            fifo_r.ts <= tsIn.ts;
         end
      end
   end

   assign fifoOut = fifo_r;
   assign matchOut = match_r;
   assign engActive = engAct_r;
   assign compActive = compAct_r;
   assign achStart = ach_r;
endmodule

// ==== rtl/fsr_pkg.sv ====
package fsr_pkg;
   localparam int FSR_FLOWS = 8;
   localparam int FSR_STAGES = 3;
   localparam int FSR_ENGINES = 3;
   localparam int FSR_SIGBYTES = 16;
   localparam logic [1:0] FSR_ENGINE_C = 2'h2;
   // register byte offsets
   localparam logic [11:0] FSR_ENG_CTRL_OFS = 12'h000;
   localparam logic [11:0] FSR_STATUS_OFS = 12'h004;
   localparam logic [11:0] FSR_COMP_EN_OFS = 12'h008;
   localparam logic [11:0] FSR_ADDR_CFG_OFS = 12'h00c;
   localparam logic [11:0] FSR_CHAN_MASK_OFS = 12'h010;
   localparam logic [11:0] FSR_PGRP_MASK_OFS = 12'h014;
   localparam logic [11:0] FSR_STAGE_EN_OFS = 12'h020;
   localparam logic [11:0] FSR_SIG_SEL_OFS = 12'h040;
   localparam logic [11:0] FSR_SIG_RD_OFS = 12'h080;
   // field positions
   localparam int FSR_STRICT_BIT = 8;
   localparam int FSR_ADDRDST_LSB = 4;
   // reset values
   localparam logic [2:0] FSR_ENG_EN_RST = 3'h0;
   localparam logic [23:0] FSR_STAGE_EN_RST = 24'h000000;
   localparam logic [8:0] FSR_COMP_EN_RST = 9'h1ff;
   localparam logic [15:0] FSR_CHAN_MASK_RST = 16'hffff;
   localparam logic [15:0] FSR_PGRP_MASK_RST = 16'hffff;
   localparam logic [5:0] FSR_SIG_SEL_RST = 6'h1b;
   // byte select codes
   localparam logic [5:0] FSR_SEL_HDR_MAX = 6'h17;
   localparam logic [5:0] FSR_SEL_HDR6 = 6'h18;
   localparam logic [5:0] FSR_SEL_HDR4 = 6'h19;
   localparam logic [5:0] FSR_SEL_HDR0 = 6'h1a;
   localparam logic [5:0] FSR_SEL_ADDR_MIN = 6'h1c;
   localparam logic [5:0] FSR_SEL_ADDR_MAX = 6'h23;
   localparam logic [5:0] FSR_HDR_TOP = 6'h1f;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } fsr_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fsr_apb_rsp_s;

   typedef struct packed {
      logic frameStart;
      logic frameEnd;
      logic chan;
      logic [1:0] engine;
      logic partB;
      logic ethFound;
      logic mplsDone;
      logic [255:0] hdr;
      logic [3:0][63:0] srcAddr;
      logic [3:0][63:0] dstAddr;
      logic [FSR_STAGES-1:0][FSR_FLOWS-1:0][1:0] hit;
   } fsr_frame_s;

   typedef struct packed {
      logic tsDone;
      logic [79:0] ts;
   } fsr_ts_s;

   typedef struct packed {
      logic valid;
      logic [127:0] sig;
      logic [79:0] ts;
   } fsr_fifo_s;

   typedef struct packed {
      logic valid;
      logic stampAll;
      logic [FSR_FLOWS-1:0] flows;
      logic [1:0] sets;
   } fsr_match_s;
endpackage
